// ===== spm_core.sv
// Byte-oriented serial master with holding registers and status flags.
module spm_core (
  // Clock and reset.
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  // Register port.
  input  wire spm_pkg::spm_reg_req_t reg_req_i,
  output logic [7:0]                 reg_rdata_o,
  // Divider tick sources from the clock unit.
  input  wire logic                  fast_tick_i,
  input  wire logic                  slow_tick_i,
  // Interrupt requests and their masks.
  input  wire logic [1:0]            irq_mask_i,
  output logic                       tx_irq_req_o,
  output logic                       rx_irq_req_o,
  // Serial pins.
  output logic                       sclk_o,
  output logic                       serial_out_pin_o,
  input  wire logic                  serial_in_pin_i
);

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  typedef struct packed {
    spm_pkg::spm_state_t st;
    logic [7:0]          enable;
    logic [7:0]          ctrl;
    logic [7:0]          clkctl;
    logic [7:0]          clkgen;
    logic [7:0]          tx_hold;
    logic [7:0]          rx_hold;
    logic                tx_empty;
    logic                rx_full;
    logic                active;
    logic [7:0]          out_sh;
    logic [7:0]          in_sh;
    logic [4:0]          edge_cnt;
    logic                sclk;
    logic                sdo;
    logic [7:0]          rdata;
    logic                irq_tx;
    logic                irq_rx;
    logic                si_s1;
    logic                si_s2;
  } spm_core_st_t;

  spm_core_st_t q;
  spm_core_st_t n;

  logic       en;
  logic       pol;
  logic       tph;
  logic       rph;
  logic       bit_order_sel;
  logic       half;
  logic       buf_in_ready;
  logic       buf_out_valid;
  logic [7:0] buf_out_data;
  logic       push;
  logic       pop;
  logic       load;
  logic       edge_ev;
  logic       odd_edge;
  logic       sample;
  logic       present;
  logic       wr_tx;
  logic       rd_rx;
  logic [7:0] src_sh;

  // ---------------------------------------------------------------
  // Decoded controls
  // ---------------------------------------------------------------
  assign en       = q.enable[spm_pkg::EN_BIT];
  assign pol      = q.clkctl[spm_pkg::CC_POL];
  assign tph      = q.clkctl[spm_pkg::CC_TPH];
  assign rph      = q.clkctl[spm_pkg::CC_RPH];
  assign bit_order_sel     = q.ctrl[spm_pkg::CT_BIT_ORDER_SEL];
  assign wr_tx    = reg_req_i.wr && (reg_req_i.addr == spm_pkg::OFS_TXHOLD);
  assign rd_rx    = reg_req_i.rd && (reg_req_i.addr == spm_pkg::OFS_RXHOLD);

  // A byte loads only when the receive side can take its answer.
  assign load     = en && (q.st == spm_pkg::ST_IDLE) && !q.tx_empty
                    && buf_in_ready;
  assign push     = (q.st == spm_pkg::ST_DONE);
  // A read in the same cycle frees the slot, so the pending byte moves now.
  assign pop      = buf_out_valid && (!q.rx_full || rd_rx);

  // Edge numbers count from one; an even counter value is an odd edge.
  assign edge_ev  = half && (q.st == spm_pkg::ST_SHIFT);
  assign odd_edge = !q.edge_cnt[0];
  assign sample   = edge_ev && (rph ? !odd_edge : odd_edge);
  assign present  = (load && !tph)
                    || (edge_ev && (tph ? odd_edge
                        : (!odd_edge && q.edge_cnt != spm_pkg::LAST_EDGE)));
  assign src_sh   = load ? q.tx_hold : q.out_sh;

  // ---------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------
  spm_clkdiv u_div (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .fast_tick_i (fast_tick_i),
    .slow_tick_i (slow_tick_i),
    .src_i       (q.clkctl[spm_pkg::CC_SRC]),
    .preload_i   (q.clkgen[5:0]),
    .run_i       (en && (q.st == spm_pkg::ST_SHIFT)),
    .half_o      (half)
  );

  // Completed bytes wait here until the receive holding register is free.
  spm_buf #(
    .W (spm_pkg::DATA_W),
    .D (spm_pkg::BUF_DEPTH)
  ) u_rxbuf (
    .clk_i       (clk_i),
    .rstn_i      (rstn_i),
    .in_valid_i  (push),
    .in_data_i   (q.in_sh),
    .in_ready_o  (buf_in_ready),
    .out_valid_o (buf_out_valid),
    .out_data_o  (buf_out_data),
    .out_ready_i (pop)
  );

  // ---------------------------------------------------------------
  // Next state
  // ---------------------------------------------------------------
  // Clears of rx_full and active are applied first so that a set in the same cycle wins.
  always_comb begin
    n = q;
    n.si_s1 = serial_in_pin_i;
    n.si_s2 = q.si_s1;

    // Register writes.
    if (reg_req_i.wr) begin
      case (reg_req_i.addr)
        spm_pkg::OFS_ENABLE: n.enable = reg_req_i.wdata & spm_pkg::WM_ENABLE;
        spm_pkg::OFS_CTRL:   n.ctrl   = reg_req_i.wdata & spm_pkg::WM_CTRL;
        spm_pkg::OFS_CLKCTL: n.clkctl = reg_req_i.wdata & spm_pkg::WM_CLKCTL;
        spm_pkg::OFS_CLKGEN: n.clkgen = reg_req_i.wdata & spm_pkg::WM_CLKGEN;
        default: ;
      endcase
    end

    // Receive read clears full, and with auto-read restarts the sender.
    if (rd_rx) begin
      n.rx_full = 1'b0;
      if (q.ctrl[spm_pkg::CT_AUTO]) begin
        n.tx_empty = 1'b0;
      end
    end

    // Moving a byte into receive holding ends the transaction.
    if (pop) begin
      n.rx_hold = buf_out_data;
      n.rx_full = 1'b1;
      n.active  = 1'b0;
    end

    // Shift engine.
    case (q.st)
      spm_pkg::ST_IDLE: begin
        n.sclk = pol;
        if (load) begin
          n.st       = spm_pkg::ST_SHIFT;
          n.edge_cnt = '0;
          n.out_sh   = q.tx_hold;
          n.tx_empty = 1'b1;
          n.active   = 1'b1;
        end
      end
      spm_pkg::ST_SHIFT: begin
        if (edge_ev) begin
          n.sclk     = !q.sclk;
          n.edge_cnt = q.edge_cnt + 5'h01;
          if (q.edge_cnt == spm_pkg::LAST_EDGE) begin
            n.st = spm_pkg::ST_DONE;
          end
        end
        if (sample) begin
          n.in_sh = bit_order_sel ? {q.si_s2, q.in_sh[7:1]}
                         : {q.in_sh[6:0], q.si_s2};
        end
      end
      spm_pkg::ST_DONE: begin
        // The buffer had room at load time, so the push always lands.
        n.st = spm_pkg::ST_IDLE;
      end
      default: n.st = spm_pkg::ST_IDLE;
    endcase

    // Present the next bit; phase zero shows bit one before any edge.
    if (present) begin
      n.sdo    = bit_order_sel ? src_sh[0] : src_sh[7];
      n.out_sh = bit_order_sel ? {1'b0, src_sh[7:1]} : {src_sh[6:0], 1'b0};
    end

    // A transmit write lands after the load, which used the old byte.
    if (wr_tx) begin
      n.tx_hold  = reg_req_i.wdata;
      n.tx_empty = 1'b0;
    end

    // Disabling abandons any byte in flight and parks the pins.
    if (!en) begin
      n.st   = spm_pkg::ST_IDLE;
      n.sclk = pol;
      n.sdo  = 1'b0;
    end

    // Read data is registered, one cycle after the strobe.
    n.rdata = 8'h00;
    if (reg_req_i.rd) begin
      case (reg_req_i.addr)
        spm_pkg::OFS_ENABLE: n.rdata = q.enable;
        spm_pkg::OFS_CTRL:   n.rdata = q.ctrl;
        spm_pkg::OFS_STATUS: n.rdata = {5'h00, q.active, q.rx_full,
                                        q.tx_empty};
        spm_pkg::OFS_TXHOLD: n.rdata = q.tx_hold;
        spm_pkg::OFS_RXHOLD: n.rdata = q.rx_hold;
        spm_pkg::OFS_CLKCTL: n.rdata = q.clkctl;
        spm_pkg::OFS_CLKGEN: n.rdata = q.clkgen;
        default:             n.rdata = 8'h00;
      endcase
    end

    // Requests follow the next flag values so they leave with the flags.
    n.irq_tx = n.tx_empty && !irq_mask_i[0];
    n.irq_rx = n.rx_full && !irq_mask_i[1];
  end

  // ---------------------------------------------------------------
  // State register
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q          <= '0;
      q.st       <= spm_pkg::ST_IDLE;
      q.enable   <= spm_pkg::RST_ENABLE;
      q.ctrl     <= spm_pkg::RST_CTRL;
      q.clkctl   <= spm_pkg::RST_CLKCTL;
      q.clkgen   <= spm_pkg::RST_CLKGEN;
      q.tx_hold  <= spm_pkg::RST_TXHOLD;
      q.rx_hold  <= spm_pkg::RST_RXHOLD;
      q.tx_empty <= 1'b1;
      q.active   <= 1'b0;
      q.irq_tx   <= 1'b0;
    end else begin
      q <= n;
    end
  end

  assign reg_rdata_o      = q.rdata;
  assign sclk_o           = q.sclk;
  assign serial_out_pin_o = q.sdo;
  assign tx_irq_req_o     = q.irq_tx;
  assign rx_irq_req_o     = q.irq_rx;

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);

  sequence tx_write_s;
    wr_tx && !reg_req_i.rd;
  endsequence

  sequence tx_readback_s;
    reg_req_i.rd && reg_req_i.addr == spm_pkg::OFS_TXHOLD && !wr_tx;
  endsequence

  write_clears_empty_a: assert property (
    tx_write_s |=> !q.tx_empty)
    else $error("Transmit write left the empty flag set.");

  read_clears_full_a: assert property (
    rd_rx && !buf_out_valid |=> !q.rx_full)
    else $error("Receive read did not clear the full flag.");

  irq_tracks_flag_a: assert property (
    rx_irq_req_o == (q.rx_full && !$past(irq_mask_i[1])))
    else $error("Receive request does not follow flag and mask.");

  load_sets_active_a: assert property (
    load |=> q.active && q.tx_empty && q.st == spm_pkg::ST_SHIFT)
    else $error("Load did not raise active and empty.");

  entry_clears_active_a: assert property (
    pop && !load |=> !q.active && q.rx_full)
    else $error("Receive entry did not drop active.");

  held_byte_kept_a: assert property (
    q.rx_full && !rd_rx |=> $stable(q.rx_hold))
    else $error("Held receive byte was overwritten.");

  refill_on_read_a: assert property (
    q.rx_full && rd_rx && buf_out_valid |=> q.rx_full)
    else $error("Pending byte did not refill receive holding.");

  tx_readback_a: assert property (
    tx_write_s ##1 tx_readback_s |=>
      reg_rdata_o == $past(reg_req_i.wdata, 2))
    else $error("Transmit holding read-back mismatch.");

  sixteen_edges_a: assert property (
    edge_ev && q.edge_cnt == spm_pkg::LAST_EDGE
      |=> q.st == spm_pkg::ST_DONE ##1 q.st == spm_pkg::ST_IDLE)
    else $error("Byte did not end after the sixteenth edge.");

  idle_level_a: assert property (
    q.st == spm_pkg::ST_IDLE && $past(q.st) == spm_pkg::ST_IDLE
      |-> sclk_o == $past(pol))
    else $error("Serial clock not at its idle level.");

  disabled_pins_a: assert property (
    !en |=> !serial_out_pin_o && q.st == spm_pkg::ST_IDLE)
    else $error("Disabled block still drives data.");

endmodule // spm_core

// ===== spm_pkg.sv
// Package with register map, field positions, reset values and types.
package spm_pkg;

  // ---------------------------------------------------------------
  // Register offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_ENABLE  = 8'h00;
  localparam logic [7:0] OFS_CTRL    = 8'h04;
  localparam logic [7:0] OFS_STATUS  = 8'h08;
  localparam logic [7:0] OFS_TXHOLD  = 8'h0c;
  localparam logic [7:0] OFS_RXHOLD  = 8'h10;
  localparam logic [7:0] OFS_CLKCTL  = 8'h14;
  localparam logic [7:0] OFS_CLKGEN  = 8'h18;

  // ---------------------------------------------------------------
  // Reset values and writable masks
  // ---------------------------------------------------------------
  localparam logic [7:0] RST_ENABLE  = 8'h00;
  localparam logic [7:0] RST_CTRL    = 8'h02;
  localparam logic [7:0] RST_CLKCTL  = 8'h02;
  localparam logic [7:0] RST_CLKGEN  = 8'h02;
  localparam logic [7:0] RST_TXHOLD  = 8'h00;
  localparam logic [7:0] RST_RXHOLD  = 8'h00;
  localparam logic [7:0] WM_ENABLE   = 8'h01;
  localparam logic [7:0] WM_CTRL     = 8'h23;
  localparam logic [7:0] WM_CLKCTL   = 8'h17;
  localparam logic [7:0] WM_CLKGEN   = 8'h3f;

  // ---------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------
  localparam int EN_BIT    = 0;
  localparam int ST_TXE    = 0;
  localparam int ST_RXF    = 1;
  localparam int ST_ACT    = 2;
  localparam int CT_BIT_ORDER_SEL   = 0;
  localparam int CT_AUTO   = 5;
  localparam int CC_TPH    = 0;
  localparam int CC_RPH    = 1;
  localparam int CC_POL    = 2;
  localparam int CC_SRC    = 4;

  // ---------------------------------------------------------------
  // Sizes and counts
  // ---------------------------------------------------------------
  localparam int         DATA_W    = 8;
  localparam int         BUF_DEPTH = 2;
  localparam logic [4:0] LAST_EDGE = 5'h0f;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spm_reg_req_t;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_SHIFT = 3'b010,
    ST_DONE  = 3'b100
  } spm_state_t;

endpackage

// ===== spm_buf.sv
// Two-entry buffer with valid and ready on both sides.
module spm_buf #(
  parameter int W = spm_pkg::DATA_W,
  parameter int D = spm_pkg::BUF_DEPTH
) (
  // Clock and reset.
  input  wire logic         clk_i,
  input  wire logic         rstn_i,
  // Filling side.
  input  wire logic         in_valid_i,
  input  wire logic [W-1:0] in_data_i,
  output logic              in_ready_o,
  // Draining side.
  output logic              out_valid_o,
  output logic [W-1:0]      out_data_o,
  input  wire logic         out_ready_i
);

  localparam int AW = (D > 1) ? $clog2(D) : 1;

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [AW:0]         cnt;
  } spm_buf_st_t;

  spm_buf_st_t q;
  spm_buf_st_t n;
  logic        push;
  logic        pop;

  // Full and empty come straight from the fill count.
  assign in_ready_o  = (q.cnt != (AW+1)'(D));
  assign out_valid_o = (q.cnt != '0);
  assign out_data_o  = q.mem[q.rp];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointers wrap at the depth, which need not be a power of two.
  always_comb begin
    n = q;
    if (push) begin
      n.mem[q.wp] = in_data_i;
      n.wp = (q.wp == AW'(D-1)) ? '0 : q.wp + 1'b1;
    end
    if (pop) begin
      n.rp = (q.rp == AW'(D-1)) ? '0 : q.rp + 1'b1;
    end
    n.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule // spm_buf

// ===== spm_clkdiv.sv
// Serial clock divider producing one pulse per half period.
module spm_clkdiv (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Tick sources and setup.
  input  wire logic       fast_tick_i,
  input  wire logic       slow_tick_i,
  input  wire logic       src_i,
  input  wire logic [5:0] preload_i,
  input  wire logic       run_i,
  // Half period pulse.
  output logic            half_o
);

  typedef struct packed {
    logic [5:0] cnt;
    logic       half;
  } spm_div_st_t;

  spm_div_st_t q;
  spm_div_st_t n;
  logic        tick;
  logic [5:0]  reload;

  // A zero preload cannot pass the source through, so it acts as one.
  assign tick   = src_i ? slow_tick_i : fast_tick_i;
  assign reload = (preload_i == 6'h00) ? 6'h00 : preload_i - 6'h01;
  assign half_o = q.half;

  // Count ticks down and pulse on reaching zero; idle holds the reload.
  always_comb begin
    n = q;
    n.half = 1'b0;
    if (!run_i) begin
      n.cnt = reload;
    end else if (tick) begin
      if (q.cnt == 6'h00) begin
        n.half = 1'b1;
        n.cnt  = reload;
      end else begin
        n.cnt = q.cnt - 6'h01;
      end
    end
  end

  // State register.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

endmodule // spm_clkdiv

// ===== spm_slave_model.sv
// Behavioural serial slave that answers the master's byte transfers.
module spm_slave_model (
  // Clock and reset.
  input  wire logic       clk_i,
  input  wire logic       rstn_i,
  // Serial pins seen from the slave.
  input  wire logic       sclk_i,
  input  wire logic       sdo_i,
  output logic            sdi_o,
  // Mode and data set by the bench.
  input  wire logic       arm_i,
  input  wire logic       tph_i,
  input  wire logic       rph_i,
  input  wire logic       bit_order_sel_i,
  input  wire logic [7:0] base_i,
  // Captured byte and edge count.
  output logic [7:0]      rx_o,
  output logic [7:0]      edges_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Edge tracking
  // ---------------------------------------------------------------
  logic       prev_q;
  logic [3:0] ph_q;
  logic [7:0] nb_q;
  logic [4:0] en;
  logic [2:0] k;
  logic [7:0] cur;

  // Each byte sent is the base plus the number of bytes already sent.
  assign en  = {1'b0, ph_q} + 5'h01;
  assign k   = 3'((en - 5'h01) >> 1);
  assign cur = base_i + nb_q;

  function automatic logic pick(input logic [7:0] b, input logic [2:0] i);
    return bit_order_sel_i ? b[i] : b[3'h7 - i];
  endfunction

  // Edges are seen one clock after the master moves its clock line.
  // While not armed the data line toggles, so stale values never match.
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prev_q  <= 1'b0;
      ph_q    <= 4'h0;
      nb_q    <= 8'h00;
      edges_o <= 8'h00;
      rx_o    <= 8'h00;
      sdi_o   <= 1'b0;
    end else begin
      prev_q <= sclk_i;
      if (!arm_i) begin
        ph_q    <= 4'h0;
        nb_q    <= 8'h00;
        edges_o <= 8'h00;
        sdi_o   <= ~sdi_o;
      end else if (sclk_i != prev_q) begin
        edges_o <= edges_o + 8'h01;
        ph_q    <= ph_q + 4'h1;
        if (en == 5'h10) nb_q <= nb_q + 8'h01;
        if (en[0] != tph_i) rx_o[bit_order_sel_i ? k : 3'h7 - k] <= sdo_i;
        if (rph_i && en[0]) sdi_o <= pick(cur, k);
        else if (!rph_i && !en[0]) sdi_o <= pick(en == 5'h10 ?
                                                 cur + 8'h01 : cur,
                                                 k + 3'h1);
        else sdi_o <= ~sdi_o;
      end else if (ph_q == 4'h0 && !rph_i) begin
        sdi_o <= pick(cur, 3'h0);
      end
    end
  end
endmodule // spm_slave_model

// ===== tb_spm_core.sv
// Self-checking bench for the serial master core with a slave model.
module tb_spm_core;
  timeunit 1ns;
  timeprecision 1ps;

  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic                  clk_i = 1'b0;
  logic                  rstn_i = 1'b0;
  spm_pkg::spm_reg_req_t req = '0;
  logic [7:0]            rdata;
  logic                  slow_tick = 1'b0;
  logic [1:0]            tick_cnt = 2'h0;
  logic [1:0]            irq_mask = 2'h0;
  logic                  tx_irq;
  logic                  rx_irq;
  logic                  sclk;
  logic                  sdo;
  logic                  sdi;
  logic                  arm = 1'b0;
  logic                  tph = 1'b0;
  logic                  rph = 1'b1;
  logic                  bit_order_sel = 1'b0;
  logic [7:0]            base = 8'h00;
  logic [7:0]            srx;
  logic [7:0]            edges;
  int                    err_count = 0;
  int                    samples_checked = 0;

  // The fast tick runs every cycle; the slow one every third cycle.
  always #5 clk_i = ~clk_i;
  always @(negedge clk_i) begin
    tick_cnt  <= (tick_cnt == 2'h2) ? 2'h0 : tick_cnt + 2'h1;
    slow_tick <= (tick_cnt == 2'h2);
  end

  spm_core u_spm_core (
    .clk_i(clk_i), .rstn_i(rstn_i), .reg_req_i(req), .reg_rdata_o(rdata),
    .fast_tick_i(1'b1), .slow_tick_i(slow_tick), .irq_mask_i(irq_mask),
    .tx_irq_req_o(tx_irq), .rx_irq_req_o(rx_irq), .sclk_o(sclk),
    .serial_out_pin_o(sdo), .serial_in_pin_i(sdi));

  spm_slave_model u_spm_slave_model (
    .clk_i(clk_i), .rstn_i(rstn_i), .sclk_i(sclk), .sdo_i(sdo),
    .sdi_o(sdi), .arm_i(arm), .tph_i(tph), .rph_i(rph), .bit_order_sel_i(bit_order_sel),
    .base_i(base), .rx_o(srx), .edges_o(edges));

  // ---------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------
  task automatic test_done;
    if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic chk(input string nm, input logic [7:0] e,
                     input logic [7:0] g);
    samples_checked++;
    if (g !== e) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Strobes are one cycle wide; read data stands the cycle after.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_i);
    req.wr = 1'b1;
    req.addr = a;
    req.wdata = d;
    @(negedge clk_i);
    req.wr = 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk_i);
    req.rd = 1'b1;
    req.addr = a;
    @(negedge clk_i);
    d = rdata;
    req.rd = 1'b0;
  endtask

  task automatic wait_st(input int b, input logic v);
    logic [7:0] s;
    for (int i = 0; i < 300; i++) begin
      rd(spm_pkg::OFS_STATUS, s);
      if (s[b] === v) return;
    end
    err_count++;
    $display("unexpected status bit %0d expected %b seen %b", b, v, s[b]);
    test_done;
  endtask

  task automatic do_reset;
    rstn_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rstn_i = 1'b1;
  endtask

  // The slave is disarmed while the clock line settles to a new level.
  task automatic cfg(input logic p, input logic t, input logic r,
                     input logic l, input logic s);
    arm = 1'b0;
    tph = t;
    rph = r;
    bit_order_sel = l;
    wr(spm_pkg::OFS_CLKCTL, {3'h0, s, 1'b0, p, r, t});
    wr(spm_pkg::OFS_CTRL, {7'h00, l});
    @(negedge clk_i);
    arm = 1'b1;
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  task automatic t_reset;
    logic [7:0] ofs [8] = '{8'h00, 8'h04, 8'h08, 8'h0c,
                            8'h10, 8'h14, 8'h18, 8'h1c};
    logic [7:0] rst [8] = '{8'h00, 8'h02, 8'h01, 8'h00,
                            8'h00, 8'h02, 8'h02, 8'h00};
    logic [7:0] v;
    for (int i = 0; i < 8; i++) begin
      rd(ofs[i], v);
      chk("reset value", rst[i], v);
    end
    wr(spm_pkg::OFS_STATUS, 8'hff);
    rd(spm_pkg::OFS_STATUS, v);
    chk("status after write", 8'h01, v);
    chk("transmit request", 8'h01, {7'h00, tx_irq});
    irq_mask = 2'h1;
    repeat (2) @(negedge clk_i);
    chk("masked transmit request", 8'h00, {7'h00, tx_irq});
    irq_mask = 2'h0;
    chk("clock when off", 8'h00, {7'h00, sclk});
    chk("data when off", 8'h00, {7'h00, sdo});
  endtask

  // Every polarity, phase and bit order combination, one byte each.
  task automatic t_xfer;
    logic [7:0] v;
    logic [7:0] txb;
    for (int m = 0; m < 16; m++) begin
      cfg(m[0], m[1], m[2], m[3], 1'b0);
      base = 8'h5a + 8'(m);
      txb = 8'hc3 ^ 8'(m * 17);
      wr(spm_pkg::OFS_TXHOLD, txb);
      rd(spm_pkg::OFS_STATUS, v);
      chk("status after load", 8'h05, v);
      wait_st(spm_pkg::ST_RXF, 1'b1);
      rd(spm_pkg::OFS_STATUS, v);
      chk("status after byte", 8'h03, v);
      chk("clock idle", {7'h00, m[0]}, {7'h00, sclk});
      chk("edge count", 8'h10, edges);
      chk("byte at slave", txb, srx);
      rd(spm_pkg::OFS_RXHOLD, v);
      chk("received byte", base, v);
      rd(spm_pkg::OFS_STATUS, v);
      chk("status after read", 8'h01, v);
      rd(spm_pkg::OFS_TXHOLD, v);
      chk("transmit readback", txb, v);
    end
  endtask

  // Second byte waits behind a busy shifter; the first is never lost.
  task automatic t_b2b;
    logic [7:0] v;
    int n;
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    base = 8'h20;
    wr(spm_pkg::OFS_TXHOLD, 8'h81);
    wr(spm_pkg::OFS_TXHOLD, 8'h42);
    rd(spm_pkg::OFS_STATUS, v);
    chk("status with byte waiting", 8'h04, v);
    for (n = 0; n < 400 && edges != 8'h20; n++) @(negedge clk_i);
    if (n == 400) begin
      err_count++;
      $display("unexpected edge count expected 20 seen %h", edges);
      test_done;
    end
    repeat (8) @(negedge clk_i);
    chk("edge count", 8'h20, edges);
    chk("byte at slave", 8'h42, srx);
    chk("receive request", 8'h01, {7'h00, rx_irq});
    irq_mask = 2'h2;
    repeat (2) @(negedge clk_i);
    chk("masked receive request", 8'h00, {7'h00, rx_irq});
    irq_mask = 2'h0;
    rd(spm_pkg::OFS_RXHOLD, v);
    chk("held byte", 8'h20, v);
    rd(spm_pkg::OFS_STATUS, v);
    chk("full after refill", 8'h03, v);
    rd(spm_pkg::OFS_RXHOLD, v);
    chk("second byte", 8'h21, v);
    rd(spm_pkg::OFS_STATUS, v);
    chk("drained status", 8'h01, v);
  endtask

  task automatic t_auto;
    logic [7:0] v;
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b0);
    base = 8'h77;
    wr(spm_pkg::OFS_CTRL, 8'h20);
    rd(spm_pkg::OFS_RXHOLD, v);
    rd(spm_pkg::OFS_STATUS, v);
    chk("active after auto read", 8'h05, v);
    wait_st(spm_pkg::ST_RXF, 1'b1);
    wr(spm_pkg::OFS_CTRL, 8'h00);
    rd(spm_pkg::OFS_RXHOLD, v);
    chk("auto read byte", 8'h77, v);
    chk("reloaded byte at slave", 8'h42, srx);
  endtask

  // Slow tick every third cycle, preload 2: six cycles per half period.
  task automatic t_src;
    logic [7:0] v;
    logic last;
    int n;
    cfg(1'b0, 1'b0, 1'b1, 1'b0, 1'b1);
    wr(spm_pkg::OFS_CLKGEN, 8'h02);
    base = 8'h99;
    wr(spm_pkg::OFS_TXHOLD, 8'h3c);
    last = sclk;
    for (n = 0; n < 100 && sclk === last; n++) @(negedge clk_i);
    if (n == 100) begin
      err_count++;
      $display("unexpected slow clock start expected 1 seen 0");
      test_done;
    end
    last = sclk;
    n = 0;
    repeat (48) begin
      @(negedge clk_i);
      if (sclk !== last) n++;
      last = sclk;
    end
    chk("slow clock edges", 8'h08, 8'(n));
    wait_st(spm_pkg::ST_RXF, 1'b1);
    rd(spm_pkg::OFS_RXHOLD, v);
    chk("slow byte", 8'h99, v);
    wr(spm_pkg::OFS_CLKGEN, 8'h04);
  endtask

  // Abort by disable mid-byte, then a second reset in mid-run.
  task automatic t_disable;
    logic [7:0] v;
    cfg(1'b1, 1'b0, 1'b1, 1'b0, 1'b0);
    wr(spm_pkg::OFS_TXHOLD, 8'hff);
    repeat (20) @(negedge clk_i);
    arm = 1'b0;
    wr(spm_pkg::OFS_ENABLE, 8'h00);
    @(negedge clk_i);
    chk("clock when off", 8'h01, {7'h00, sclk});
    chk("data when off", 8'h00, {7'h00, sdo});
    do_reset;
    rd(spm_pkg::OFS_STATUS, v);
    chk("status after reset", 8'h01, v);
    rd(spm_pkg::OFS_CLKCTL, v);
    chk("clock control after reset", 8'h02, v);
  endtask

  initial begin
    do_reset;
    t_reset;
    wr(spm_pkg::OFS_ENABLE, 8'h01);
    wr(spm_pkg::OFS_CLKGEN, 8'h04);
    t_xfer;
    t_b2b;
    t_auto;
    t_src;
    t_disable;
    test_done;
  end
endmodule // tb_spm_core
